// ===== rtl/dtcr_cfg.svh
/*
  Constants of the dual timer with capture/reload register: register byte
  offsets, field positions, reset values and pin indices.
  Assumes it is included by bare name from rtl/ and tb/ sources.
*/
`ifndef DTCR_CFG_SVH
`define DTCR_CFG_SVH

// Register byte offsets
`define DTCR_OFS_AUX_CTRL   5'h00
`define DTCR_OFS_CORE_CTRL  5'h04
`define DTCR_OFS_AUX_CNT    5'h08
`define DTCR_OFS_CORE_CNT   5'h0c
`define DTCR_OFS_CAPTURE_RELOAD_REGISTER     5'h10
`define DTCR_OFS_CAP_CTRL   5'h14
`define DTCR_OFS_FLAGS      5'h18

// Timer control fields
`define DTCR_F_SEL_LO       0
`define DTCR_F_SEL_HI       2
`define DTCR_F_EXT          3
`define DTCR_F_LATCH_CLK    4
`define DTCR_F_DOWN         5
`define DTCR_F_DIR_PIN_EN   6
`define DTCR_F_RUN          7
`define DTCR_F_OUT_EN       8
`define DTCR_F_RELOAD_EN    9
`define DTCR_F_CC0_SEL      10
`define DTCR_F_CC1_SEL      11

// Capture control fields
`define DTCR_F_CAP_EN       0
`define DTCR_F_EDGE_LO      1
`define DTCR_F_EDGE_HI      2
`define DTCR_F_CLR_ON_CAP   3
`define DTCR_F_TRIG_LO      4
`define DTCR_F_TRIG_HI      5

// Flag fields
`define DTCR_F_CORE_WRAP    0
`define DTCR_F_AUX_WRAP     1
`define DTCR_F_CAPTURE      2
`define DTCR_F_LATCH        3

// Reset values
`define DTCR_RST_CTRL       16'h0000
`define DTCR_RST_CNT        16'h0000
`define DTCR_RST_FLAGS      3'h0

// Prescaler: smallest divider is 4, eight steps of two
`define DTCR_PRE_BASE       10'h004
`define DTCR_PRE_W          9

// Synchronised pin indices
`define DTCR_PIN_AUX_IN     0
`define DTCR_PIN_CORE_IN    1
`define DTCR_PIN_AUX_DIR    2
`define DTCR_PIN_CORE_DIR   3
`define DTCR_PIN_CAPTURE_INPUT_PIN      4
`define DTCR_PIN_QUAD_CNT   5
`define DTCR_PIN_QUAD_DIR   6
`define DTCR_PIN_NUM        7

`endif

// ===== rtl/dtcr_pkg.sv
/*
  Types of the dual timer with capture/reload register.
  Assumes nothing of its surroundings.
*/
package dtcr_pkg;
  typedef logic [15:0] dtcr_word_t;
  typedef logic [31:0] dtcr_data_t;
  typedef logic [4:0]  dtcr_addr_t;

  typedef enum logic [1:0] {
    DTCR_EDGE_NONE = 2'h0,
    DTCR_EDGE_RISE = 2'h1,
    DTCR_EDGE_FALL = 2'h2,
    DTCR_EDGE_BOTH = 2'h3
  } dtcr_edge_t;

  typedef enum logic [1:0] {
    DTCR_TRIG_CAPTURE_INPUT_PIN    = 2'h0,
    DTCR_TRIG_QUAD_CNT = 2'h1,
    DTCR_TRIG_QUAD_DIR = 2'h2,
    DTCR_TRIG_QUAD_ALL = 2'h3
  } dtcr_trig_t;
endpackage : dtcr_pkg

// ===== rtl/dtcr_sync.sv
/*
  Two-stage synchroniser with edge detect for a group of input pins.
  Assumes pins are asynchronous levels; edges appear one to two clocks late.
*/
`timescale 1ns/1ps
`default_nettype none
module dtcr_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         reset_n,
  input  wire logic [W-1:0] pins,
  output logic      [W-1:0] level,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  logic [W-1:0] prev_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_d;
  logic [W-1:0] prev_d;

  always_comb
  begin
    meta_d = pins;
    sync_d = meta_q;
    prev_d = sync_q;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      prev_q <= prev_d;
    end
  end

  // Edges look only at the second stage and its delayed copy
  assign level = sync_q;
  assign rise  = sync_q & ~prev_q;
  assign fall  = ~sync_q & prev_q;
endmodule : dtcr_sync
`default_nettype wire

// ===== rtl/dtcr_timer.sv
/*
  One up/down counter with load, clear, reload-on-wrap and a wrap pulse.
  Assumes step, load and clear are single-cycle pulses from the top.
*/
`timescale 1ns/1ps
`default_nettype none
module dtcr_timer #(
  parameter int W = 16
) (
  input  wire logic         clk,
  input  wire logic         reset_n,
  input  wire logic         step,
  input  wire logic         down,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  input  wire logic         clear,
  input  wire logic         reload_en,
  input  wire logic [W-1:0] reload_val,
  output logic      [W-1:0] cnt_q,
  output logic              wrap_q
);
  logic [W-1:0] cnt_d;
  logic         wrap_d;

  always_comb
  begin
    cnt_d  = cnt_q;
    wrap_d = 1'b0;
    if (load)
      cnt_d = load_val;
    else if (clear)
      cnt_d = '0;
    else if (step)
    begin
      if (down)
      begin
        wrap_d = (cnt_q == '0);
        cnt_d  = cnt_q - 1'b1;
      end
      else
      begin
        wrap_d = (cnt_q == '1);
        cnt_d  = cnt_q + 1'b1;
      end
      if (wrap_d && reload_en)
        cnt_d = reload_val;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cnt_q  <= '0;
      wrap_q <= 1'b0;
    end
    else
    begin
      cnt_q  <= cnt_d;
      wrap_q <= wrap_d;
    end
  end
endmodule : dtcr_timer
`default_nettype wire

// ===== rtl/dtcr_top.sv
/*
  Dual timer with capture/reload register: an auxiliary and a core timer,
  prescaler, toggle latch, capture/reload logic, request flags and an
  Avalon-MM slave with waitrequest.
  Assumes one 10 MHz clock, pins treated as asynchronous and synchronised here.
*/
// Decided for this implementation: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "dtcr_cfg.svh"
module dtcr_top #(
  parameter int TW = 16
) (
  input  wire logic               clk,
  input  wire logic               reset_n,
  input  wire dtcr_pkg::dtcr_addr_t address,
  input  wire logic               read,
  input  wire logic               write,
  input  wire dtcr_pkg::dtcr_data_t writedata,
  input  wire logic [3:0]         byteenable,
  output dtcr_pkg::dtcr_data_t    readdata,
  output logic                    waitrequest,
  input  wire logic               aux_input_pin,
  input  wire logic               core_input_pin,
  input  wire logic               aux_direction_input_pin,
  input  wire logic               core_direction_input_pin,
  input  wire logic               capture_input_pin,
  input  wire logic               quadrature_count_input,
  input  wire logic               quadrature_direction_input,
  output logic                    toggle_output_pin,
  output logic                    toggle_output_pin_oe,
  output logic                    first_compare_timer_clk,
  output logic                    second_compare_timer_clk,
  output logic                    core_req,
  output logic                    aux_req,
  output logic                    capture_req
);
  import dtcr_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Declarations
  dtcr_word_t                aux_ctrl_q;
  dtcr_word_t                aux_ctrl_d;
  dtcr_word_t                core_ctrl_q;
  dtcr_word_t                core_ctrl_d;
  dtcr_word_t                cap_ctrl_q;
  dtcr_word_t                cap_ctrl_d;
  logic [TW-1:0]             capture_reload_register_q;
  logic [TW-1:0]             capture_reload_register_d;
  logic [2:0]                flags_q;
  logic [2:0]                flags_d;
  logic                      latch_q;
  logic                      latch_d;
  logic [`DTCR_PRE_W-1:0]    pre_q;
  logic [`DTCR_PRE_W-1:0]    pre_d;
  dtcr_data_t                rdata_q;
  dtcr_data_t                rdata_d;
  logic                      wait_q;
  logic                      wait_d;
  logic                      tout_q;
  logic                      tout_d;
  logic                      toe_q;
  logic                      toe_d;
  logic                      cc0_q;
  logic                      cc0_d;
  logic                      cc1_q;
  logic                      cc1_d;

  logic [`DTCR_PIN_NUM-1:0]  pin_raw;
  logic [`DTCR_PIN_NUM-1:0]  pin_lvl;
  logic [`DTCR_PIN_NUM-1:0]  pin_rise;
  logic [`DTCR_PIN_NUM-1:0]  pin_fall;

  logic [TW-1:0]             aux_cnt;
  logic [TW-1:0]             core_cnt;
  logic                      aux_wrap;
  logic                      core_wrap;
  logic                      aux_step;
  logic                      core_step;
  logic                      aux_down;
  logic                      core_down;
  logic                      aux_tick;
  logic                      core_tick;
  logic [`DTCR_PRE_W-1:0]    aux_mask;
  logic [`DTCR_PRE_W-1:0]    core_mask;
  logic                      latch_edge;
  logic                      cap_hit;
  logic                      cap_evt;
  logic                      wr_commit;
  logic                      aux_load;
  logic                      core_load;
  logic [TW-1:0]             aux_load_val;
  logic [TW-1:0]             core_load_val;
  logic [2:0]                flag_clr;
  logic [2:0]                flag_set;
  dtcr_edge_t                edge_sel;
  dtcr_trig_t                trig_sel;

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  // sample pins first
  assign pin_raw = {quadrature_direction_input, quadrature_count_input, capture_input_pin,
                    core_direction_input_pin, aux_direction_input_pin, core_input_pin, aux_input_pin};

  dtcr_sync #(
    .W (`DTCR_PIN_NUM)
  ) u_sync (
    .clk     (clk),
    .reset_n (reset_n),
    .pins    (pin_raw),
    .level   (pin_lvl),
    .rise    (pin_rise),
    .fall    (pin_fall)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Byte-lane merge for register writes
  function automatic dtcr_word_t merge(input dtcr_word_t old, input dtcr_data_t wd, input logic [3:0] be);
    dtcr_word_t r;
    r[7:0]  = be[0] ? wd[7:0]  : old[7:0];
    r[15:8] = be[1] ? wd[15:8] : old[15:8];
    return r;
  endfunction : merge

  //////////////////////////////////////////////////////////////////////////////
  // Count enables
  always_comb
  begin
    pre_d = pre_q + 1'b1;
    aux_mask  = `DTCR_PRE_W'((`DTCR_PRE_BASE << aux_ctrl_q[`DTCR_F_SEL_HI:`DTCR_F_SEL_LO]) - 10'h001);
    core_mask = `DTCR_PRE_W'((`DTCR_PRE_BASE << core_ctrl_q[`DTCR_F_SEL_HI:`DTCR_F_SEL_LO]) - 10'h001);
    aux_tick  = &(pre_q | ~aux_mask);
    core_tick = &(pre_q | ~core_mask);
    latch_edge = latch_q ^ latch_d;

    if (core_ctrl_q[`DTCR_F_EXT])
      core_step = pin_rise[`DTCR_PIN_CORE_IN];
    else
      core_step = core_tick;
    if (aux_ctrl_q[`DTCR_F_LATCH_CLK])
      aux_step = latch_edge;
    else if (aux_ctrl_q[`DTCR_F_EXT])
      aux_step = pin_rise[`DTCR_PIN_AUX_IN];
    else
      aux_step = aux_tick;
    aux_step  = aux_step & aux_ctrl_q[`DTCR_F_RUN];
    core_step = core_step & core_ctrl_q[`DTCR_F_RUN];

    aux_down  = aux_ctrl_q[`DTCR_F_DOWN] ^
                (aux_ctrl_q[`DTCR_F_DIR_PIN_EN] & pin_lvl[`DTCR_PIN_AUX_DIR]);
    core_down = core_ctrl_q[`DTCR_F_DOWN] ^
                (core_ctrl_q[`DTCR_F_DIR_PIN_EN] & pin_lvl[`DTCR_PIN_CORE_DIR]);
  end

  //////////////////////////////////////////////////////////////////////////////
  // Timers
  // two timers
  dtcr_timer #(
    .W (TW)
  ) u_aux (
    .clk        (clk),
    .reset_n    (reset_n),
    .step       (aux_step),
    .down       (aux_down),
    .load       (aux_load),
    .load_val   (aux_load_val),
    .clear      (cap_evt && cap_ctrl_q[`DTCR_F_CLR_ON_CAP]),
    .reload_en  (1'b0),
    .reload_val (capture_reload_register_q),
    .cnt_q      (aux_cnt),
    .wrap_q     (aux_wrap)
  );

  dtcr_timer #(
    .W (TW)
  ) u_core (
    .clk        (clk),
    .reset_n    (reset_n),
    .step       (core_step),
    .down       (core_down),
    .load       (core_load),
    .load_val   (core_load_val),
    .clear      (1'b0),
    .reload_en  (core_ctrl_q[`DTCR_F_RELOAD_EN]),
    .reload_val (capture_reload_register_q),
    .cnt_q      (core_cnt),
    .wrap_q     (core_wrap)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Capture, latch, flags and pins
  always_comb
  begin
    edge_sel = dtcr_edge_t'(cap_ctrl_q[`DTCR_F_EDGE_HI:`DTCR_F_EDGE_LO]);
    trig_sel = dtcr_trig_t'(cap_ctrl_q[`DTCR_F_TRIG_HI:`DTCR_F_TRIG_LO]);
    case (trig_sel)
      DTCR_TRIG_CAPTURE_INPUT_PIN:    cap_hit = (edge_sel[0] & pin_rise[`DTCR_PIN_CAPTURE_INPUT_PIN]) |
                                    (edge_sel[1] & pin_fall[`DTCR_PIN_CAPTURE_INPUT_PIN]);
      DTCR_TRIG_QUAD_CNT: cap_hit = pin_rise[`DTCR_PIN_QUAD_CNT] | pin_fall[`DTCR_PIN_QUAD_CNT];
      DTCR_TRIG_QUAD_DIR: cap_hit = pin_rise[`DTCR_PIN_QUAD_DIR] | pin_fall[`DTCR_PIN_QUAD_DIR];
      DTCR_TRIG_QUAD_ALL: cap_hit = pin_rise[`DTCR_PIN_QUAD_CNT] | pin_fall[`DTCR_PIN_QUAD_CNT] |
                                    pin_rise[`DTCR_PIN_QUAD_DIR] | pin_fall[`DTCR_PIN_QUAD_DIR];
      default:            cap_hit = 1'b0;
    endcase
    cap_evt = cap_hit & cap_ctrl_q[`DTCR_F_CAP_EN];

    latch_d = latch_q ^ core_wrap;
    tout_d = latch_q;
    toe_d  = core_ctrl_q[`DTCR_F_OUT_EN];
    cc0_d = core_wrap & core_ctrl_q[`DTCR_F_CC0_SEL];
    cc1_d = core_wrap & core_ctrl_q[`DTCR_F_CC1_SEL];

    flag_set = '0;
    flag_set[`DTCR_F_CORE_WRAP] = core_wrap;
    flag_set[`DTCR_F_AUX_WRAP]  = aux_wrap;
    flag_set[`DTCR_F_CAPTURE]   = cap_evt;
    flag_clr = '0;
    if (wr_commit && address == `DTCR_OFS_FLAGS && byteenable[0])
      flag_clr = writedata[2:0];
    flags_d = (flags_q & ~flag_clr) | flag_set;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Avalon-MM slave
  always_comb
  begin
    wr_commit = write & ~wait_q;
    wait_d    = ~((read | write) & wait_q);
    aux_ctrl_d  = aux_ctrl_q;
    core_ctrl_d = core_ctrl_q;
    cap_ctrl_d  = cap_ctrl_q;
    capture_reload_register_d    = capture_reload_register_q;
    aux_load      = 1'b0;
    core_load     = 1'b0;
    aux_load_val  = merge(aux_cnt, writedata, byteenable);
    core_load_val = merge(core_cnt, writedata, byteenable);
    if (wr_commit)
    begin
      case (address)
        `DTCR_OFS_AUX_CTRL:  aux_ctrl_d  = merge(aux_ctrl_q, writedata, byteenable);
        `DTCR_OFS_CORE_CTRL: core_ctrl_d = merge(core_ctrl_q, writedata, byteenable);
        `DTCR_OFS_CAP_CTRL:  cap_ctrl_d  = merge(cap_ctrl_q, writedata, byteenable);
        `DTCR_OFS_AUX_CNT:   aux_load    = 1'b1;
        `DTCR_OFS_CORE_CNT:  core_load   = 1'b1;
        `DTCR_OFS_CAPTURE_RELOAD_REGISTER:    capture_reload_register_d    = merge(capture_reload_register_q, writedata, byteenable);
        default:             capture_reload_register_d    = capture_reload_register_q;
      endcase
    end
    if (cap_evt)
      capture_reload_register_d = aux_cnt;

    rdata_d = '0;
    if (read && wait_q)
    begin
      case (address)
        `DTCR_OFS_AUX_CTRL:  rdata_d[15:0] = aux_ctrl_q;
        `DTCR_OFS_CORE_CTRL: rdata_d[15:0] = core_ctrl_q;
        `DTCR_OFS_CAP_CTRL:  rdata_d[15:0] = cap_ctrl_q;
        `DTCR_OFS_AUX_CNT:   rdata_d[15:0] = aux_cnt;
        `DTCR_OFS_CORE_CNT:  rdata_d[15:0] = core_cnt;
        `DTCR_OFS_CAPTURE_RELOAD_REGISTER:    rdata_d[15:0] = capture_reload_register_q;
        `DTCR_OFS_FLAGS:     rdata_d[3:0]  = {latch_q, flags_q};
        default:             rdata_d       = '0;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // State registers
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      aux_ctrl_q  <= `DTCR_RST_CTRL;
      core_ctrl_q <= `DTCR_RST_CTRL;
      cap_ctrl_q  <= `DTCR_RST_CTRL;
      capture_reload_register_q    <= `DTCR_RST_CNT;
      flags_q     <= `DTCR_RST_FLAGS;
      latch_q     <= 1'b0;
      pre_q       <= '0;
      rdata_q     <= '0;
      wait_q      <= 1'b1;
      tout_q      <= 1'b0;
      toe_q       <= 1'b0;
      cc0_q       <= 1'b0;
      cc1_q       <= 1'b0;
    end
    else
    begin
      aux_ctrl_q  <= aux_ctrl_d;
      core_ctrl_q <= core_ctrl_d;
      cap_ctrl_q  <= cap_ctrl_d;
      capture_reload_register_q    <= capture_reload_register_d;
      flags_q     <= flags_d;
      latch_q     <= latch_d;
      pre_q       <= pre_d;
      rdata_q     <= rdata_d;
      wait_q      <= wait_d;
      tout_q      <= tout_d;
      toe_q       <= toe_d;
      cc0_q       <= cc0_d;
      cc1_q       <= cc1_d;
    end
  end

  assign readdata                 = rdata_q;
  assign waitrequest              = wait_q;
  assign toggle_output_pin        = tout_q;
  assign toggle_output_pin_oe     = toe_q;
  assign first_compare_timer_clk  = cc0_q;
  assign second_compare_timer_clk = cc1_q;
  assign core_req                 = flags_q[`DTCR_F_CORE_WRAP];
  assign aux_req                  = flags_q[`DTCR_F_AUX_WRAP];
  assign capture_req              = flags_q[`DTCR_F_CAPTURE];
endmodule : dtcr_top
`default_nettype wire

// ===== tb/dtcr_monitor.sv
/*
  Checker on the ports of dtcr_top: bus answer, toggle latch, flags.
  Assumes one clock domain and the offsets and fields of dtcr_cfg.svh.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dtcr_cfg.svh"
module dtcr_monitor (
  input wire logic                 clk,
  input wire logic                 reset_n,
  input wire dtcr_pkg::dtcr_addr_t address,
  input wire logic                 read,
  input wire logic                 write,
  input wire dtcr_pkg::dtcr_data_t writedata,
  input wire logic [3:0]           byteenable,
  input wire dtcr_pkg::dtcr_data_t readdata,
  input wire logic                 waitrequest,
  input wire logic                 toggle_output_pin,
  input wire logic                 toggle_output_pin_oe,
  input wire logic                 first_compare_timer_clk,
  input wire logic                 second_compare_timer_clk,
  input wire logic                 core_req,
  input wire logic                 capture_req
);
  import dtcr_pkg::*;
  logic wr_done, oe_wr, oe_val, clr_core, clr_cap;
  assign wr_done = write && !waitrequest;
  assign oe_wr = wr_done && address == `DTCR_OFS_CORE_CTRL && byteenable[1];
  assign oe_val = writedata[`DTCR_F_OUT_EN];
  assign clr_core = wr_done && address == `DTCR_OFS_FLAGS && byteenable[0] && writedata[0];
  assign clr_cap = wr_done && address == `DTCR_OFS_FLAGS && byteenable[0] && writedata[2];
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  sequence s_take;
    (read || write) && waitrequest;
  endsequence
  sequence s_answer;
    !waitrequest ##1 waitrequest;
  endsequence
  a_bus_answer:
    assert property (s_take |=> s_answer) else $error("bus answer not one cycle");
  a_rd_idle:
    assert property (waitrequest |-> readdata == '0) else $error("read data outside answer");
  a_rd_width:
    assert property (readdata[31:16] == 16'h0000) else $error("read data above 16 bits");
  a_oe_write:
    assert property ($changed(toggle_output_pin_oe) |-> $past(oe_wr, 2) && toggle_output_pin_oe == $past(oe_val, 2))
    else $error("toggle enable moved without write");
  a_latch_req:
    assert property ($changed(toggle_output_pin) |-> $past(core_req)) else $error("toggle without core wrap flag");
  a_cmp0_pulse:
    assert property (first_compare_timer_clk |=> $changed(toggle_output_pin) && !first_compare_timer_clk)
    else $error("compare clock 0 not a wrap pulse");
  a_cmp1_pulse:
    assert property (second_compare_timer_clk |=> $changed(toggle_output_pin) && !second_compare_timer_clk)
    else $error("compare clock 1 not a wrap pulse");
  a_core_clear:
    assert property ($fell(core_req) |-> $past(clr_core)) else $error("core flag dropped unasked");
  a_cap_clear:
    assert property ($fell(capture_req) |-> $past(clr_cap)) else $error("capture flag dropped unasked");
endmodule : dtcr_monitor
bind dtcr_top dtcr_monitor i_dtcr_monitor (.clk(clk), .reset_n(reset_n), .address(address), .read(read),
  .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
  .waitrequest(waitrequest), .toggle_output_pin(toggle_output_pin), .toggle_output_pin_oe(toggle_output_pin_oe),
  .first_compare_timer_clk(first_compare_timer_clk), .second_compare_timer_clk(second_compare_timer_clk),
  .core_req(core_req), .capture_req(capture_req));
`default_nettype wire

// ===== tb/dtcr_pin_model.sv
/*
  Pin model: drives the event, direction, capture and quadrature pins.
  Assumes the bench calls set_pin; a pin moves only after a rising edge.
*/
`timescale 1ns/1ps
`default_nettype none
module dtcr_pin_model (
  input  wire logic       clk,
  output logic      [6:0] pins
);
  initial pins = 7'h00;
  task automatic set_pin(input int idx, input logic v);
    @(posedge clk);
    pins[idx] <= v;
    repeat (5) @(posedge clk);
  endtask : set_pin
endmodule : dtcr_pin_model
`default_nettype wire

// ===== tb/tb_dtcr_top.sv
/*
  Self-checking bench for dtcr_top: Avalon-MM tasks, pin model, scenarios.
  Assumes the offsets and fields of dtcr_cfg.svh and a 10 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dtcr_cfg.svh"
module tb_dtcr_top;
  import dtcr_pkg::*;
  logic       clk = 1'b0;
  logic       reset_n = 1'b0;
  dtcr_addr_t address = '0;
  logic       read = 1'b0;
  logic       write = 1'b0;
  dtcr_data_t writedata = '0;
  logic [3:0] byteenable = 4'hf;
  dtcr_data_t readdata;
  logic       waitrequest, tog, tog_oe, cmp0, cmp1, core_req, aux_req, capture_req, tog_prev;
  logic [6:0] pins;
  wire  [2:0] reqs = {capture_req, aux_req, core_req};
  int         errors = 0;
  int         samples_checked = 0;
  int         cycles = 0;
  int         toggles = 0;
  always #50 clk = ~clk;
  dtcr_top i_dtcr_top (.clk(clk), .reset_n(reset_n), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .aux_input_pin(pins[`DTCR_PIN_AUX_IN]), .core_input_pin(pins[`DTCR_PIN_CORE_IN]),
    .aux_direction_input_pin(pins[`DTCR_PIN_AUX_DIR]), .core_direction_input_pin(pins[`DTCR_PIN_CORE_DIR]),
    .capture_input_pin(pins[`DTCR_PIN_CAPTURE_INPUT_PIN]), .quadrature_count_input(pins[`DTCR_PIN_QUAD_CNT]),
    .quadrature_direction_input(pins[`DTCR_PIN_QUAD_DIR]), .toggle_output_pin(tog),
    .toggle_output_pin_oe(tog_oe), .first_compare_timer_clk(cmp0), .second_compare_timer_clk(cmp1),
    .core_req(core_req), .aux_req(aux_req), .capture_req(capture_req));
  dtcr_pin_model i_dtcr_pin_model (.clk(clk), .pins(pins));
  ////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : finish_test
  task automatic check(input dtcr_data_t seen, input dtcr_data_t exp);
    samples_checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic bus(input logic wr, input dtcr_addr_t a, input dtcr_data_t d, output dtcr_data_t q);
    @(posedge clk);
    read <= !wr;
    write <= wr;
    address <= a;
    writedata <= d;
    // Answer is seen where it stands; the following rising edge commits it
    do @(negedge clk); while (waitrequest !== 1'b0);
    q = readdata;
    @(posedge clk);
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus
  task automatic wr(input dtcr_addr_t a, input dtcr_data_t d);
    dtcr_data_t q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input dtcr_addr_t a, input dtcr_data_t exp);
    dtcr_data_t q;
    bus(1'b0, a, '0, q);
    check(q, exp);
  endtask : rd
  task automatic wait_req(input int k);
    int n;
    n = 0;
    while (reqs[k] !== 1'b1 && n < 2000)
    begin
      @(negedge clk);
      n++;
    end
    check(dtcr_data_t'(reqs[k]), 32'h1);
  endtask : wait_req
  ////////////////////////////////////////////////////////////
  task automatic t_prescale();
    dtcr_data_t q0, q1;
    for (int s = 0; s < 8; s++)
    begin
      i_dtcr_pin_model.set_pin(`DTCR_PIN_AUX_DIR, s[1]);
      wr(`DTCR_OFS_AUX_CTRL, dtcr_data_t'(32'hc0 | s | ((s & 1) << 5)));
      bus(1'b0, `DTCR_OFS_AUX_CNT, '0, q0);
      repeat ((16 << s) - 3) @(posedge clk);
      bus(1'b0, `DTCR_OFS_AUX_CNT, '0, q1);
      check(dtcr_data_t'(16'(q1[15:0] - q0[15:0])), (s[0] ^ s[1]) ? 32'hfffc : 32'h4);
    end
    wr(`DTCR_OFS_AUX_CTRL, '0);
  endtask : t_prescale
  task automatic t_core_wrap();
    dtcr_data_t q;
    wr(`DTCR_OFS_FLAGS, 32'h7);
    wr(`DTCR_OFS_CAPTURE_RELOAD_REGISTER, 32'hfff0);
    wr(`DTCR_OFS_CORE_CNT, 32'hfffd);
    wr(`DTCR_OFS_CORE_CTRL, 32'hf80);
    wait_req(0);
    check(dtcr_data_t'({tog_oe, cmp0, cmp1}), 32'h7);
    @(negedge clk);
    check(dtcr_data_t'({tog, cmp0, cmp1}), 32'h4);
    bus(1'b0, `DTCR_OFS_CORE_CNT, '0, q);
    check(q >= 32'hfff0 && q < 32'hfff8, 32'h1);
    wr(`DTCR_OFS_CORE_CTRL, '0);
    repeat (8) @(posedge clk);
    rd(`DTCR_OFS_FLAGS, 32'h9);
    wr(`DTCR_OFS_FLAGS, 32'h7);
    @(negedge clk);
    check(reqs, '0);
  endtask : t_core_wrap
  task automatic t_chain();
    int n0;
    wr(`DTCR_OFS_AUX_CNT, 32'hfffe);
    wr(`DTCR_OFS_AUX_CTRL, 32'h88);
    repeat (3)
    begin
      i_dtcr_pin_model.set_pin(`DTCR_PIN_AUX_IN, 1'b1);
      i_dtcr_pin_model.set_pin(`DTCR_PIN_AUX_IN, 1'b0);
    end
    rd(`DTCR_OFS_AUX_CNT, 32'h1);
    wait_req(1);
    wr(`DTCR_OFS_AUX_CNT, '0);
    wr(`DTCR_OFS_AUX_CTRL, 32'h90);
    wr(`DTCR_OFS_CAPTURE_RELOAD_REGISTER, 32'hfffc);
    n0 = toggles;
    wr(`DTCR_OFS_CORE_CTRL, 32'h380);
    repeat (200) @(posedge clk);
    wr(`DTCR_OFS_CORE_CTRL, 32'h100);
    repeat (10) @(posedge clk);
    rd(`DTCR_OFS_AUX_CNT, dtcr_data_t'(toggles - n0));
    wr(`DTCR_OFS_AUX_CTRL, '0);
    wr(`DTCR_OFS_FLAGS, 32'h7);
  endtask : t_chain
  task automatic t_capture();
    wr(`DTCR_OFS_AUX_CNT, 32'h1234);
    wr(`DTCR_OFS_CAP_CTRL, 32'h0b);
    i_dtcr_pin_model.set_pin(`DTCR_PIN_CAPTURE_INPUT_PIN, 1'b1);
    wait_req(2);
    rd(`DTCR_OFS_CAPTURE_RELOAD_REGISTER, 32'h1234);
    rd(`DTCR_OFS_AUX_CNT, 32'h0);
    wr(`DTCR_OFS_AUX_CNT, 32'h55);
    wr(`DTCR_OFS_CAP_CTRL, 32'h05);
    wr(`DTCR_OFS_FLAGS, 32'h4);
    i_dtcr_pin_model.set_pin(`DTCR_PIN_CAPTURE_INPUT_PIN, 1'b0);
    rd(`DTCR_OFS_CAPTURE_RELOAD_REGISTER, 32'h55);
    wr(`DTCR_OFS_FLAGS, 32'h4);
    wr(`DTCR_OFS_AUX_CNT, 32'h66);
    i_dtcr_pin_model.set_pin(`DTCR_PIN_CAPTURE_INPUT_PIN, 1'b1);
    rd(`DTCR_OFS_CAPTURE_RELOAD_REGISTER, 32'h55);
    wr(`DTCR_OFS_CAP_CTRL, 32'h07);
    i_dtcr_pin_model.set_pin(`DTCR_PIN_CAPTURE_INPUT_PIN, 1'b0);
    rd(`DTCR_OFS_CAPTURE_RELOAD_REGISTER, 32'h66);
    wr(`DTCR_OFS_FLAGS, 32'h4);
    for (int k = 1; k < 4; k++)
    begin
      wr(`DTCR_OFS_CAP_CTRL, dtcr_data_t'(32'h1 | (k << 4)));
      wr(`DTCR_OFS_AUX_CNT, dtcr_data_t'(32'h100 + k));
      i_dtcr_pin_model.set_pin(k == 2 ? `DTCR_PIN_QUAD_DIR : `DTCR_PIN_QUAD_CNT, k != 3);
      wait_req(2);
      rd(`DTCR_OFS_CAPTURE_RELOAD_REGISTER, dtcr_data_t'(32'h100 + k));
      wr(`DTCR_OFS_FLAGS, 32'h4);
    end
  endtask : t_capture
  ////////////////////////////////////////////////////////////
  always @(negedge clk)
  begin
    if (tog !== tog_prev)
      toggles++;
    tog_prev = tog;
  end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      errors++;
      finish_test();
    end
  end
  initial
  begin
    tog_prev = 1'b0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    for (int a = 0; a < 8; a++)
      rd(dtcr_addr_t'(a * 4), '0);
    t_prescale();
    t_core_wrap();
    t_chain();
    t_capture();
    finish_test();
  end
endmodule : tb_dtcr_top
`default_nettype wire
